// file: bench/sls_far_model.sv
`timescale 1ns/1ps
module sls_far_model import sls_pkg::*; (
    input wire logic clock,
    input wire logic power_on,
    input wire logic send_pkt,
    input wire sls_link_t link_q,
    output logic remote_powerup,
    output logic ctrl_packet_seen,
    output logic locked
);
    // Dummy wake packet carries no payload, only presence
    assign remote_powerup = power_on;
    assign ctrl_packet_seen = send_pkt;
    always_ff @(posedge clock) begin
        locked <= link_q.video_link_on || link_q.config_link_on;
    end
endmodule

// file: bench/sls_seq_assertions.sv
`timescale 1ns/1ps
`include "sls_consts.svh"
module sls_seq_assertions import sls_pkg::*; #(
    parameter int unsigned SLEEP_CYC = 20,
    parameter int unsigned CC_BLOCK_CYC = 10
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic autostart_select_pin,
    input wire logic application_direction_select,
    input wire logic remote_powerup,
    input wire logic ctrl_packet_seen,
    input wire logic video_valid,
    input wire logic [7:0] video_data,
    input wire sls_bus_req_t bus_req,
    input wire sls_link_t link_q,
    input wire logic ser_valid,
    input wire logic [7:0] ser_data
);
    int unsigned age_q, cc_q;
    logic quiet_q, en_seen_q;
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            age_q <= 0;
            cc_q <= 1000;
            quiet_q <= 1'b1;
            en_seen_q <= 1'b0;
        end else begin
            age_q <= age_q + (age_q < 1000);
            cc_q <= $rose(remote_powerup) ? 0 : cc_q + (cc_q < 1000);
            quiet_q <= quiet_q && !bus_req.wr && !ctrl_packet_seen;
            en_seen_q <= en_seen_q || (bus_req.wr && bus_req.addr == `SLS_REG_CTRL
                && bus_req.data[`SLS_CTRL_SER_LINK_EN]);
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    vid_pclk_a: assert property (
        $rose(link_q.video_link_on) |-> link_q.pclk_valid) else $error("video without clock");
    ser_follow_a: assert property (
        video_valid && link_q.video_link_on |=> ser_valid && ser_data == $past(video_data))
        else $error("video byte not forwarded");
    auto_start_a: assert property (
        (!autostart_select_pin && age_q > 8 && link_q.pclk_valid) [*6] |-> link_q.video_link_on)
        else $error("autostart did not bring video up");
    disp_sleep_a: assert property (
        !application_direction_select && $rose(link_q.sleeping)
        |-> $past(bus_req.wr) || $past(bus_req.wr, 2) || $past(bus_req.wr, 3))
        else $error("display sequence slept unasked");
    sleep_early_a: assert property (
        age_q < SLEEP_CYC |-> !link_q.sleeping) else $error("sleep came too early");
    sleep_late_a: assert property (
        application_direction_select && autostart_select_pin && quiet_q
        && age_q == SLEEP_CYC + 8 |-> link_q.sleeping) else $error("timed sleep missing");
    cc_block_a: assert property (
        cc_q >= 4 && cc_q < CC_BLOCK_CYC |-> !link_q.ctrl_chan_ok)
        else $error("control channel open in blackout");
    disp_start_a: assert property (
        !application_direction_select && autostart_select_pin && $rose(link_q.video_link_on)
        |-> en_seen_q) else $error("video started without command");
    cover property ($rose(link_q.sleeping));
    cover property ($rose(link_q.video_link_on));
    cover property (ser_valid);
endmodule
bind sls_sequencer sls_seq_assertions #(.SLEEP_CYC(SLEEP_CYC), .CC_BLOCK_CYC(CC_BLOCK_CYC))
    u_chk (.*);

// file: bench/sls_tb.sv
`timescale 1ns/1ps
`include "sls_consts.svh"
module tb;
    import sls_pkg::*;
    localparam int SC = 20;
    localparam int CB = 10;
    logic clock = 0, rst_b = 0, auto_b = 1, dir = 0, pclk = 0, pwr = 0, pkt = 0, vv = 0;
    logic [7:0] vd = 8'h00;
    sls_bus_req_t req = '0;
    logic [7:0] rd_data, ser_data;
    sls_link_t link_q;
    logic ser_valid, remote_powerup, ctrl_packet_seen, locked;
    int fail_count = 0, cmp_count = 0, seed = 32'h42dfc82b;
    sls_sequencer #(.SLEEP_CYC(SC), .CC_BLOCK_CYC(CB), .WAKE_CYC(15)) dut (
        .clock(clock), .rst_b(rst_b), .autostart_select_pin(auto_b),
        .application_direction_select(dir), .pixel_clock_present(pclk),
        .remote_powerup(remote_powerup), .ctrl_packet_seen(ctrl_packet_seen),
        .video_valid(vv), .video_data(vd), .bus_req(req), .rd_data(rd_data),
        .link_q(link_q), .ser_valid(ser_valid), .ser_data(ser_data));
    sls_far_model far (.clock(clock), .power_on(pwr), .send_pkt(pkt), .link_q(link_q),
        .remote_powerup(remote_powerup), .ctrl_packet_seen(ctrl_packet_seen),
        .locked(locked));
    initial begin
        forever #10 clock = ~clock;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic clk(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        req <= '{data: d, addr: a, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        req <= '0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        req <= '{data: 8'h00, addr: a, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        req <= '0;
        #1 chk(rd_data, exp);
        @(posedge clock);
    endtask
    task automatic boot(input logic a, input logic d);
        rst_b <= 1'b0;
        auto_b <= a;
        dir <= d;
        clk(20);
        rst_b <= 1'b1;
    endtask
    task automatic wait_video();
        for (int i = 0; i < 60 && link_q.video_link_on !== 1'b1; i++) clk(1);
    endtask
    task automatic tally_and_finish();
        $display("comparisons=%0d mismatches=%0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        clk(6000);
        fail_count++;
        tally_and_finish();
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        logic [8:0] s, p;
        boot(1'b0, 1'b0);
        clk(30);
        chk(link_q.video_link_on, 1'b0);
        pclk <= 1'b1;
        wait_video();
        chk(link_q.video_link_on, 1'b1);
        p = 9'h000;
        repeat (64) begin
            s = 9'($random(seed));
            vv <= s[8];
            vd <= s[7:0];
            #1 chk(ser_valid, p[8]);
            if (p[8]) chk(ser_data, p[7:0]);
            p = s;
            @(posedge clock);
        end
        vv <= 1'b0;
        chk(locked, 1'b1);
        // Manual start in display use: config link first, then video
        boot(1'b1, 1'b0);
        clk(40);
        chk(link_q.video_link_on, 1'b0);
        chk(link_q.sleeping, 1'b0);
        rd(4'hC, 8'h00);
        wr(`SLS_REG_CTRL, 8'h02);
        clk(6);
        chk(link_q.config_link_on, 1'b1);
        rd(`SLS_REG_CTRL, 8'h02);
        wr(`SLS_REG_CTRL, 8'h01);
        wait_video();
        chk(link_q.video_link_on, 1'b1);
        chk(link_q.config_link_on, 1'b0);
        wr(`SLS_REG_CTRL, 8'h05);
        clk(4);
        chk(link_q.sleeping, 1'b1);
        // Image sensing: timed sleep, packet wake, late far-end power-up
        boot(1'b1, 1'b1);
        clk(SC - 4);
        chk(link_q.sleeping, 1'b0);
        clk(12);
        chk(link_q.sleeping, 1'b1);
        pkt <= 1'b1;
        clk(1);
        pkt <= 1'b0;
        clk(4);
        wr(`SLS_REG_CTRL, 8'h01);
        wait_video();
        chk(link_q.sleeping, 1'b0);
        chk(link_q.video_link_on, 1'b1);
        pwr <= 1'b1;
        clk(6);
        chk(link_q.ctrl_chan_ok, 1'b0);
        clk(CB + 10);
        chk(link_q.ctrl_chan_ok, 1'b1);
        rd(`SLS_REG_STAT, 8'h13);
        tally_and_finish();
    end
endmodule

// file: hw/sls_sequencer.sv
`timescale 1ns/1ps
`include "sls_consts.svh"
module sls_sequencer import sls_pkg::*; #(
    parameter int unsigned SLEEP_CYC = `SLS_SLEEP_CYC,
    parameter int unsigned CC_BLOCK_CYC = `SLS_CC_BLOCK_CYC,
    parameter int unsigned WAKE_CYC = `SLS_WAKE_CYC
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic autostart_select_pin,
    input wire logic application_direction_select,
    input wire logic pixel_clock_present,
    input wire logic remote_powerup,
    input wire logic ctrl_packet_seen,
    input wire logic video_valid,
    input wire logic [7:0] video_data,
    input wire sls_bus_req_t bus_req,
    output logic [7:0] rd_data,
    output sls_link_t link_q,
    output logic ser_valid,
    output logic [7:0] ser_data
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [4:0] meta_q;
    logic [4:0] sync_q;
    logic [4:0] meta_d;
    logic [4:0] sync_d;
    logic auto_pin_s, dir_s, pclk_s, remote_s, pkt_s;
    logic remote_prev_q, remote_prev_d;

    always_comb begin
        meta_d = {ctrl_packet_seen, remote_powerup, pixel_clock_present,
                  application_direction_select, autostart_select_pin};
        sync_d = meta_q;
        remote_prev_d = remote_s;
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            meta_q <= 5'h00;
            sync_q <= 5'h00;
            remote_prev_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            remote_prev_q <= remote_prev_d;
        end
    end

    assign {pkt_s, remote_s, pclk_s, dir_s, auto_pin_s} = sync_q;

    // ----------------------------------------
    // Straps caught after reset release
    // ----------------------------------------
    // Synchroniser needs two edges before straps are meaningful
    logic [1:0] boot_q, boot_d;
    logic auto_mode_q, auto_mode_d;
    logic sense_mode_q, sense_mode_d;

    always_comb begin
        boot_d = boot_q;
        auto_mode_d = auto_mode_q;
        sense_mode_d = sense_mode_q;
        if (boot_q != 2'h3) begin
            boot_d = boot_q + 2'h1;
        end
        if (boot_q == 2'h2) begin
            auto_mode_d = !auto_pin_s;
            sense_mode_d = dir_s;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            boot_q <= 2'h0;
            auto_mode_q <= 1'b0;
            sense_mode_q <= 1'b0;
        end else begin
            boot_q <= boot_d;
            auto_mode_q <= auto_mode_d;
            sense_mode_q <= sense_mode_d;
        end
    end

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] rd_d;
    logic ser_link_en, cfg_link_en, sleep_bit;
    sls_state_t state_q, state_d;
    sls_link_t link_d;

    assign ser_link_en = ctrl_q[`SLS_CTRL_SER_LINK_EN];
    assign cfg_link_en = ctrl_q[`SLS_CTRL_CFG_LINK_EN];
    assign sleep_bit = ctrl_q[`SLS_CTRL_SLEEP];

    always_comb begin
        ctrl_d = ctrl_q;
        rd_d = 8'h00;
        if (bus_req.wr && bus_req.addr == `SLS_REG_CTRL) begin
            ctrl_d = bus_req.data;
            ctrl_d[7:3] = 5'h00;
        end
        // Timed sleep entry sets the bit so software sees it
        if (state_q != SLS_ST_SLEEP && state_d == SLS_ST_SLEEP) begin
            ctrl_d[`SLS_CTRL_SLEEP] = 1'b1;
        end
        if (bus_req.rd) begin
            case (bus_req.addr)
                `SLS_REG_CTRL: rd_d = ctrl_q;
                `SLS_REG_STAT: rd_d = {3'h0, link_q};
                default: rd_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ctrl_q <= `SLS_CTRL_RST;
            rd_data <= 8'h00;
        end else begin
            ctrl_q <= ctrl_d;
            rd_data <= rd_d;
        end
    end

    // ----------------------------------------
    // Start-up sequencer
    // ----------------------------------------
    // One counter serves sleep timer and wake hold; channel blackout has its own cc_cnt_q
    logic [31:0] cnt_q, cnt_d;
    logic [31:0] cc_cnt_q, cc_cnt_d;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            SLS_ST_DEFAULTS: begin
                cnt_d = 32'h0;
                if (boot_q == 2'h3) begin
                    state_d = SLS_ST_IDLE;
                end
            end
            SLS_ST_IDLE: begin
                cnt_d = cnt_q + 32'h1;
                if (auto_mode_q || ser_link_en) begin
                    state_d = SLS_ST_WAIT_CLK;
                end else if (cfg_link_en) begin
                    state_d = SLS_ST_CFG_LINK;
                end else if (sense_mode_q && cnt_q >= SLEEP_CYC - 1) begin
                    state_d = SLS_ST_SLEEP;
                end
                // Manual-start display sequence idles here until commanded
                if (sleep_bit && !sense_mode_q && !auto_mode_q) begin
                    state_d = SLS_ST_SLEEP;
                end
            end
            SLS_ST_CFG_LINK: begin
                if (ser_link_en) begin
                    state_d = SLS_ST_WAIT_CLK;
                end else if (!cfg_link_en) begin
                    state_d = SLS_ST_IDLE;
                end
            end
            SLS_ST_WAIT_CLK: begin
                if (pclk_s) begin
                    state_d = SLS_ST_VIDEO;
                end else if (!ser_link_en && !auto_mode_q) begin
                    state_d = cfg_link_en ? SLS_ST_CFG_LINK : SLS_ST_IDLE;
                end
            end
            SLS_ST_VIDEO: begin
                if (!pclk_s) begin
                    state_d = SLS_ST_WAIT_CLK;
                end else if (!ser_link_en && !auto_mode_q) begin
                    state_d = cfg_link_en ? SLS_ST_CFG_LINK : SLS_ST_IDLE;
                end
                if (sleep_bit) begin
                    state_d = SLS_ST_SLEEP;
                end
            end
            SLS_ST_SLEEP: begin
                cnt_d = 32'h0;
                if (pkt_s) begin
                    state_d = SLS_ST_WAKING;
                end
            end
            SLS_ST_WAKING: begin
                // Wake is only kept if software clears sleep in time
                cnt_d = cnt_q + 32'h1;
                if (!sleep_bit) begin
                    state_d = SLS_ST_IDLE;
                    cnt_d = 32'h0;
                end else if (cnt_q >= WAKE_CYC - 1) begin
                    state_d = SLS_ST_SLEEP;
                end
            end
            default: begin
                state_d = SLS_ST_DEFAULTS;
            end
        endcase
        if (state_q == SLS_ST_IDLE && sleep_bit && !(state_d == SLS_ST_SLEEP)) begin
            if (sense_mode_q && !auto_mode_q) begin
                state_d = SLS_ST_SLEEP;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state_q <= SLS_ST_DEFAULTS;
            cnt_q <= 32'h0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // ----------------------------------------
    // Control channel blackout after late far-end power-up
    // ----------------------------------------
    always_comb begin
        cc_cnt_d = cc_cnt_q;
        if (remote_s && !remote_prev_q) begin
            cc_cnt_d = CC_BLOCK_CYC;
        end else if (cc_cnt_q != 32'h0) begin
            cc_cnt_d = cc_cnt_q - 32'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cc_cnt_q <= 32'h0;
        end else begin
            cc_cnt_q <= cc_cnt_d;
        end
    end

    // ----------------------------------------
    // Link status and video path
    // ----------------------------------------
    logic ser_valid_d;
    logic [7:0] ser_data_d;

    always_comb begin
        link_d.video_link_on = (state_d == SLS_ST_VIDEO);
        link_d.config_link_on = (state_d == SLS_ST_CFG_LINK);
        link_d.sleeping = (state_d == SLS_ST_SLEEP);
        link_d.ctrl_chan_ok = (state_d == SLS_ST_VIDEO || state_d == SLS_ST_CFG_LINK)
                              && (cc_cnt_d == 32'h0);
        link_d.pclk_valid = pclk_s;
        ser_valid_d = (state_q == SLS_ST_VIDEO) && video_valid;
        ser_data_d = ser_valid_d ? video_data : 8'h00;
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            link_q <= '0;
            ser_valid <= 1'b0;
            ser_data <= 8'h00;
        end else begin
            link_q <= link_d;
            ser_valid <= ser_valid_d;
            ser_data <= ser_data_d;
        end
    end
endmodule

// file: shared/sls_consts.svh
`ifndef SLS_CONSTS_SVH
`define SLS_CONSTS_SVH

// ----------------------------------------
// Register offsets and fields
// ----------------------------------------
`define SLS_ADDR_W 4
`define SLS_REG_CTRL 4'h0
`define SLS_REG_STAT 4'h4
`define SLS_CTRL_SER_LINK_EN 0
`define SLS_CTRL_CFG_LINK_EN 1
`define SLS_CTRL_SLEEP 2
`define SLS_CTRL_RST 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define SLS_CLK_HZ 50000000
`define SLS_SLEEP_DELAY_US 8000
`define SLS_CC_BLOCK_US 2000
`define SLS_WAKE_HOLD_US 5000
`define SLS_SLEEP_CYC ((`SLS_CLK_HZ / 1000000) * `SLS_SLEEP_DELAY_US)
`define SLS_CC_BLOCK_CYC ((`SLS_CLK_HZ / 1000000) * `SLS_CC_BLOCK_US)
`define SLS_WAKE_CYC ((`SLS_CLK_HZ / 1000000) * `SLS_WAKE_HOLD_US)
`endif

// file: shared/sls_pkg.sv
package sls_pkg;
    typedef enum logic [2:0] {
        SLS_ST_DEFAULTS,
        SLS_ST_IDLE,
        SLS_ST_CFG_LINK,
        SLS_ST_WAIT_CLK,
        SLS_ST_VIDEO,
        SLS_ST_SLEEP,
        SLS_ST_WAKING
    } sls_state_t;

    typedef struct packed {
        logic [7:0] data;
        logic [3:0] addr;
        logic wr;
        logic rd;
    } sls_bus_req_t;

    typedef struct packed {
        logic video_link_on;
        logic config_link_on;
        logic sleeping;
        logic ctrl_chan_ok;
        logic pclk_valid;
    } sls_link_t;
endpackage
